// ### dv/otfr_fault_response_tb_top.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Bench for the over-temperature response block
// ----------------------------------------------------------------
module otfr_fault_response_tb_top
  import otfr_pkg::*;
;
  logic mclk = 1'b0, resetn = 1'b0, ot_fault = 1'b0, unit_tick = 1'b0;
  logic output_on_cmd = 1'b1, bias_ok = 1'b1, other_fault_off = 1'b0;
  logic cmd_wr, clear_status_bit, clear_faults_cmd;
  logic [7:0] cmd_code, cmd_wdata, action_rdata_q;
  logic output_enable_q, fault_latched_q;
  logic [7:0] v;
  int error_cnt = 0, check_count = 0, seed = 26;

  always #5 mclk = ~mclk;

  otfr_host_model otfr_host_model_inst (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .clear_faults_cmd(clear_faults_cmd),
    .clear_status_bit(clear_status_bit));

  otfr_fault_response otfr_fault_response_inst (.mclk(mclk), .resetn(resetn),
    .cmd_wr(cmd_wr), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .ot_fault(ot_fault),
    .unit_tick(unit_tick), .clear_status_bit(clear_status_bit),
    .clear_faults_cmd(clear_faults_cmd), .output_on_cmd(output_on_cmd), .bias_ok(bias_ok),
    .other_fault_off(other_fault_off), .action_rdata_q(action_rdata_q),
    .output_enable_q(output_enable_q), .fault_latched_q(fault_latched_q));

  // Single comparison point
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Unit ticks spaced so each timer decision lands before the next
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge mclk) unit_tick = 1'b1;
      @(negedge mclk) unit_tick = 1'b0;
      repeat (3) @(negedge mclk);
    end
  endtask : ticks

  // Reference: output is back on only if attempts outlast the faulty decisions
  function automatic logic exp_on(input int r, input int held);
    return (r == 7) || (held < r);
  endfunction : exp_on

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Watchdog sized well above the expected run
  initial begin
    #200us;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    chk("rdata_rst", action_rdata_q, OTFR_ACTION_RST);
    chk("oe_rst", {7'h0, output_enable_q}, 8'h01);
    v = 8'($random(seed));
    otfr_host_model_inst.write_cfg(v);
    chk("rdata", action_rdata_q, v);
    $display("test setting done");
    // Ignore: keeps regulating, status still set
    otfr_host_model_inst.write_cfg(8'h00);
    ot_fault = 1'b1;
    repeat (3) @(negedge mclk);
    chk("oe_ignore", {7'h0, output_enable_q}, 8'h01);
    chk("latched", {7'h0, fault_latched_q}, 8'h01);
    ot_fault = 1'b0;
    otfr_host_model_inst.clear(1'b1);
    chk("latched_clr", {7'h0, fault_latched_q}, 8'h00);
    $display("test ignore done");
    // Disable and retry over every retry code and a random delay
    for (int r = 0; r < 8; r++) begin
      for (int h = 0; h < 2; h++) begin
        int d;
        int held;
        d = $unsigned($random(seed)) % 3;
        held = (r == 7) ? 9 : r - 1 + h;
        if (held < 0) held = 0;
        otfr_host_model_inst.write_cfg({OTFR_RESP_RETRY, r[2:0], d[2:0]});
        ot_fault = 1'b1;
        @(negedge mclk);
        @(negedge mclk);
        chk("oe_off", {7'h0, output_enable_q}, 8'h00);
        ticks(held << d);
        ot_fault = 1'b0;
        ticks(1 << d);
        chk("oe_retry", {7'h0, output_enable_q}, {7'h0, exp_on(r, held)});
        otfr_host_model_inst.clear(h[0]);
        chk("oe_clear", {7'h0, output_enable_q}, 8'h01);
      end
    end
    // A clear mid-episode hands back the attempt that was spent
    otfr_host_model_inst.write_cfg({OTFR_RESP_RETRY, 3'h1, 3'h0});
    ot_fault = 1'b1;
    ticks(1);
    otfr_host_model_inst.clear(1'b0);
    @(negedge mclk) ot_fault = 1'b0;
    ticks(1);
    chk("oe_reload", {7'h0, output_enable_q}, 8'h01);
    $display("test retry done");
    // Delay mode: stays on until the delay runs out with the fault present
    otfr_host_model_inst.write_cfg({OTFR_RESP_DELAY, OTFR_RETRY_NONE, 3'h2});
    ot_fault = 1'b1;
    ticks(3);
    chk("oe_delay", {7'h0, output_enable_q}, 8'h01);
    ticks(1);
    chk("oe_expired", {7'h0, output_enable_q}, 8'h00);
    ot_fault = 1'b0;
    // Delay that runs out then follows the retry field
    otfr_host_model_inst.write_cfg({OTFR_RESP_DELAY, 3'h1, 3'h0});
    ot_fault = 1'b1;
    ticks(1);
    chk("oe_delay_end", {7'h0, output_enable_q}, 8'h00);
    ot_fault = 1'b0;
    ticks(1);
    chk("oe_delay_retry", {7'h0, output_enable_q}, 8'h01);
    $display("test delay done");
    // Latch mode over commanded off/on and bias loss
    for (int k = 0; k < 2; k++) begin
      otfr_host_model_inst.write_cfg({OTFR_RESP_LATCH, 6'h00});
      ot_fault = 1'b1;
      @(negedge mclk) ot_fault = 1'b0;
      ticks(2);
      chk("oe_latch", {7'h0, output_enable_q}, 8'h00);
      if (k == 0) output_on_cmd = 1'b0;
      else bias_ok = 1'b0;
      @(negedge mclk);
      output_on_cmd = 1'b1;
      bias_ok = 1'b1;
      repeat (2) @(negedge mclk);
      chk("oe_cycle", {7'h0, output_enable_q}, 8'h01);
      chk("latched_cycle", {7'h0, fault_latched_q}, 8'h00);
    end
    // Endless retry ends in latch when another fault shuts down
    otfr_host_model_inst.write_cfg({OTFR_RESP_RETRY, OTFR_RETRY_ENDLESS, 3'h0});
    ot_fault = 1'b1;
    ticks(2);
    @(negedge mclk) other_fault_off = 1'b1;
    @(negedge mclk) other_fault_off = 1'b0;
    ot_fault = 1'b0;
    ticks(2);
    chk("oe_other", {7'h0, output_enable_q}, 8'h00);
    $display("test latch done");
    // Reset in mid-run clears the latched shutdown and the setting
    @(negedge mclk) resetn = 1'b0;
    repeat (2) @(negedge mclk);
    resetn = 1'b1;
    @(negedge mclk);
    chk("oe_reset", {7'h0, output_enable_q}, 8'h01);
    chk("latched_reset", {7'h0, fault_latched_q}, 8'h00);
    chk("rdata_reset", action_rdata_q, OTFR_ACTION_RST);
    $display("test reset done");
    conclude();
  end
endmodule : otfr_fault_response_tb_top

// ### dv/otfr_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host side: writes the setting and issues fault clears
// ----------------------------------------------------------------
module otfr_host_model
  import otfr_pkg::*;
(
  input  wire logic mclk,
  output logic      cmd_wr,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata,
  output logic      clear_faults_cmd,
  output logic      clear_status_bit
);
  // Idle values; an idle bus never repeats the last byte
  initial begin
    cmd_wr           = 1'b0;
    cmd_code         = 8'h00;
    cmd_wdata        = 8'h00;
    clear_faults_cmd = 1'b0;
    clear_status_bit = 1'b0;
  end

  // One byte write, held across one sampling edge
  task automatic write_cfg(input logic [7:0] d);
    @(negedge mclk);
    cmd_wr    = 1'b1;
    cmd_code  = OTFR_ACTION_CMD;
    cmd_wdata = d;
    @(negedge mclk);
    cmd_wr    = 1'b0;
    cmd_code  = ~OTFR_ACTION_CMD;
    cmd_wdata = ~d;
  endtask : write_cfg

  // Clear by command or by the single status bit
  task automatic clear(input bit by_cmd);
    @(negedge mclk);
    if (by_cmd) clear_faults_cmd = 1'b1;
    else clear_status_bit = 1'b1;
    @(negedge mclk);
    clear_faults_cmd = 1'b0;
    clear_status_bit = 1'b0;
  endtask : clear
endmodule : otfr_host_model

// ### logic/otfr_delay_timer.sv
`timescale 1ns/10ps
module otfr_delay_timer
  import otfr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [2:0] delay_code,
  input  wire logic       unit_tick,
  output logic            done_q
);

  // ----------------------------------------------------------------
  // Unit countdown
  // ----------------------------------------------------------------
  logic [7:0] remain_q;
  logic [7:0] remain_d;
  logic [7:0] units;
  logic       expire;

  // Code n loads 2**n units, 1 to 128
  assign units    = 8'h01 << delay_code;
  assign expire   = unit_tick && (remain_q == 8'h01);
  assign remain_d = start ? units : (unit_tick && remain_q != 8'h00) ? remain_q - 8'h01 : remain_q;

  // Start restarts the span, so spacing runs from each attempt's start
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      remain_q <= 8'h00;
      done_q   <= 1'b0;
    end else begin
      remain_q <= remain_d;
      done_q   <= expire && !start;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  timer_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    start |=> remain_q == (8'h01 << $past(delay_code)))
    else $error("delay timer loaded wrong unit count");

  done_on_tick_a: assert property (@(posedge mclk) disable iff (!resetn)
    done_q |-> $past(unit_tick) && $past(remain_q) == 8'h01)
    else $error("delay timer expired off a unit tick");

endmodule : otfr_delay_timer

// ### logic/otfr_fault_response.sv
`timescale 1ns/10ps
module otfr_fault_response
  import otfr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic       ot_fault,
  input  wire logic       unit_tick,
  input  wire logic       clear_status_bit,
  input  wire logic       clear_faults_cmd,
  input  wire logic       output_on_cmd,
  input  wire logic       bias_ok,
  input  wire logic       other_fault_off,
  output logic [7:0]      action_rdata_q,
  output logic            output_enable_q,
  output logic            fault_latched_q
);

  // ----------------------------------------------------------------
  // Setting register
  // ----------------------------------------------------------------
  otfr_action_s action_q;
  logic         action_wr;

  assign action_wr = cmd_wr && (cmd_code == OTFR_ACTION_CMD);

  // Written whole, read back unchanged
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      action_q       <= OTFR_ACTION_RST;
      action_rdata_q <= OTFR_ACTION_RST;
    end else if (action_wr) begin
      action_q       <= cmd_wdata;
      action_rdata_q <= cmd_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Clear events
  // ----------------------------------------------------------------
  // Held off or bias missing acts as a standing clear, so an
  // off-then-on sequence leaves the block clean when it turns back on
  logic clr;

  assign clr = clear_status_bit || clear_faults_cmd || !output_on_cmd || !bias_ok;

  // ----------------------------------------------------------------
  // Attempt counter and next state
  // ----------------------------------------------------------------
  otfr_state_e state_q;
  otfr_state_e state_d;
  logic [2:0]  attempts_q;
  logic [2:0]  attempts_d;
  logic        timer_start;
  logic        timer_done;
  logic        endless;
  logic        have_attempt;
  logic        shut_state;

  assign endless      = action_q.retries == OTFR_RETRY_ENDLESS;
  assign have_attempt = endless || (attempts_q != 3'h0);
  // A fault in disable-and-retry mode, or a delay that ran out, picks retry or latch;
  // high when the shutdown must latch at once instead of waiting to retry
  assign shut_state   = (action_q.retries == OTFR_RETRY_NONE);

  always_comb begin
    state_d     = state_q;
    attempts_d  = attempts_q;
    timer_start = 1'b0;
    if (clr || action_wr) begin
      state_d    = OTFR_ST_RUN;
      attempts_d = action_wr ? cmd_wdata[OTFR_RETRY_POS +: 3] : action_q.retries;
    end else begin
      case (state_q)
        OTFR_ST_RUN: begin
          if (ot_fault) begin
            case (action_q.resp)
              OTFR_RESP_IGNORE: state_d = OTFR_ST_RUN;
              OTFR_RESP_DELAY: begin
                state_d     = OTFR_ST_DELAY;
                timer_start = 1'b1;
              end
              OTFR_RESP_RETRY: begin
                state_d     = otfr_state_e'(shut_state ? OTFR_ST_LATCH : OTFR_ST_HOLD);
                timer_start = 1'b1;
              end
              default: state_d = OTFR_ST_LATCH;
            endcase
          end
        end
        OTFR_ST_DELAY: begin
          if (!ot_fault) begin
            state_d = OTFR_ST_RUN;
          end else if (timer_done) begin
            state_d     = otfr_state_e'(shut_state ? OTFR_ST_LATCH : OTFR_ST_HOLD);
            timer_start = 1'b1;
          end
        end
        OTFR_ST_HOLD: begin
          if (other_fault_off) begin
            state_d = OTFR_ST_LATCH;
          end else if (timer_done) begin
            if (!have_attempt) begin
              state_d = OTFR_ST_LATCH;
            end else begin
              attempts_d  = endless ? attempts_q : attempts_q - 3'h1;
              // A failed attempt restarts the spacing from its own start
              state_d     = ot_fault ? OTFR_ST_HOLD : OTFR_ST_RUN;
              timer_start = ot_fault;
            end
          end
        end
        OTFR_ST_LATCH: state_d = OTFR_ST_LATCH;
        default:       state_d = OTFR_ST_LATCH;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State, output enable and fault status
  // ----------------------------------------------------------------
  logic out_en_d;

  assign out_en_d = (state_d == OTFR_ST_RUN || state_d == OTFR_ST_DELAY)
                    && output_on_cmd && bias_ok;

  // Status sets on any fault, even when ignored; a set beats a clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q         <= OTFR_ST_RUN;
      attempts_q      <= 3'h0;
      output_enable_q <= 1'b0;
      fault_latched_q <= 1'b0;
    end else begin
      state_q         <= state_d;
      attempts_q      <= attempts_d;
      output_enable_q <= out_en_d;
      fault_latched_q <= ot_fault || (fault_latched_q && !clr);
    end
  end

  otfr_delay_timer u_timer (
    .mclk       (mclk),
    .resetn     (resetn),
    .start      (timer_start),
    .delay_code (action_q.delay),
    .unit_tick  (unit_tick),
    .done_q     (timer_done)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ignore_keeps_run_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_RUN && ot_fault && action_q.resp == OTFR_RESP_IGNORE
    && !clr && !action_wr |=> state_q == OTFR_ST_RUN && output_enable_q)
    else $error("ignore mode interrupted the output");

  delay_keeps_on_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_DELAY |-> output_enable_q)
    else $error("output dropped during run-on delay");

  retry_disables_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_RUN && ot_fault && action_q.resp == OTFR_RESP_RETRY
    && !clr && !action_wr |=> !output_enable_q)
    else $error("disable-and-retry left output on");

  latch_holds_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_LATCH && !clr && !action_wr |=> state_q == OTFR_ST_LATCH
    && !output_enable_q)
    else $error("latched shutdown left without a clear");

  clear_status_a: assert property (@(posedge mclk) disable iff (!resetn)
    clr && !ot_fault |=> !fault_latched_q && state_q == OTFR_ST_RUN)
    else $error("clear did not release the fault");

  no_retry_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_RUN && ot_fault && action_q.resp == OTFR_RESP_RETRY
    && action_q.retries == OTFR_RETRY_NONE && !clr && !action_wr
    |=> state_q == OTFR_ST_LATCH)
    else $error("retry none still entered restart wait");

  attempts_spent_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_HOLD && timer_done && attempts_q == 3'h0 && !endless
    && !clr && !action_wr |=> state_q == OTFR_ST_LATCH)
    else $error("restart made with no attempts left");

  endless_retry_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_HOLD && timer_done && endless && ot_fault && !other_fault_off
    && !clr && !action_wr |=> state_q == OTFR_ST_HOLD && attempts_q == $past(attempts_q))
    else $error("endless retry gave up");

  reload_count_a: assert property (@(posedge mclk) disable iff (!resetn)
    clr && !action_wr |=> attempts_q == $past(action_q.retries))
    else $error("attempt counter not reloaded on clear");

  // A write reloads the attempts as well as the readback
  write_reload_a: assert property (@(posedge mclk) disable iff (!resetn)
    action_wr |=> attempts_q == $past(cmd_wdata[OTFR_RETRY_POS +: 3])
    && action_rdata_q == $past(cmd_wdata))
    else $error("setting write did not reload attempts");

  // Status follows the fault in every mode, ignore included
  status_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    ot_fault |=> fault_latched_q)
    else $error("fault status not set");

  delay_expiry_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_DELAY && ot_fault && timer_done && !clr && !action_wr
    |=> !output_enable_q)
    else $error("output kept on after run-on delay ran out");

  // Unless retry is endless, each failed decision spends exactly one attempt
  attempt_used_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_HOLD && timer_done && !endless && attempts_q != 3'h0
    && !other_fault_off && !clr && !action_wr |=> attempts_q == $past(attempts_q) - 3'h1)
    else $error("restart attempt not counted");

  restart_on_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_HOLD && timer_done && have_attempt && !ot_fault
    && !other_fault_off && !clr && !action_wr |=> state_q == OTFR_ST_RUN && output_enable_q)
    else $error("restart with fault gone left output off");

  other_fault_a: assert property (@(posedge mclk) disable iff (!resetn)
    state_q == OTFR_ST_HOLD && other_fault_off && !clr && !action_wr
    |=> state_q == OTFR_ST_LATCH)
    else $error("retrying went on after another fault shut down");

endmodule : otfr_fault_response

// ### logic/otfr_pkg.sv
// Overview of operation
// - Response 00: ignore fault, keep regulating
// - Response 01: run for delay, then retry
// - Response 10: disable at once, then retry
// - Response 11: disable until fault cleared
// - Clear by bit, command, reset, cycle, bias
// - Retry 000: no restart, stay off
// - Retry 001-100: one to four attempts
// - Attempt spacing equals two-to-delay-field units
// - Retry 101/110 five, six; 111 unlimited
// - Delay code n gives two-to-n units
package otfr_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] OTFR_ACTION_CMD = 8'h50;
  localparam logic [7:0] OTFR_ACTION_RST = 8'h00;
  localparam int         OTFR_RESP_POS   = 6;
  localparam int         OTFR_RETRY_POS  = 3;
  localparam int         OTFR_DELAY_POS  = 0;

  // Response codes, bits 7:6
  localparam logic [1:0] OTFR_RESP_IGNORE = 2'h0;
  localparam logic [1:0] OTFR_RESP_DELAY  = 2'h1;
  localparam logic [1:0] OTFR_RESP_RETRY  = 2'h2;
  localparam logic [1:0] OTFR_RESP_LATCH  = 2'h3;

  // Retry codes, bits 5:3
  localparam logic [2:0] OTFR_RETRY_NONE    = 3'h0;
  localparam logic [2:0] OTFR_RETRY_ENDLESS = 3'h7;

  // Setting as carried between logic
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retries;
    logic [2:0] delay;
  } otfr_action_s;

  // Fault handling states
  typedef enum logic [3:0] {
    OTFR_ST_RUN   = 4'h1,
    OTFR_ST_DELAY = 4'h2,
    OTFR_ST_HOLD  = 4'h4,
    OTFR_ST_LATCH = 4'h8
  } otfr_state_e;

endpackage : otfr_pkg
